// ==== src/aic_bank.sv ====
// Module: APB register bank and scan sequencer of the two-in, one-out analog channel group
// Function
// - Control bit selects voltage or current mode for input one; software reads and writes it.
// - Control bit selects voltage or current mode for input two; software reads and writes it.
// - Control bit selects voltage or current drive for the analog output.
// - On controller stop output holds last value, or drops to offset when cancel set.
// - Input one converts while its disable bit is clear, unused while set.
// - Input two converts while its disable bit is clear, unused while set.
// - Output drives while its disable bit is clear, unused while set.
// - Error bits 0 and 1 flag over-scale on input one and input two.
// - Error bit 2 flags invalid output setting; bit 3 has no meaning.
// - Error bit 4 flags memory fault; bit 5 flags averaging count out of range.
// - Error bit 6 flags hardware fault; bit 7 corrupt converter data; word readable, writable.
// - Conversion results and output setting are 12-bit binary values.
// - Input results refresh once per averaging count of scans, output once per scan; 90 us per enabled input, 50 us per output.
// - Output codes 0 through 4000 span the full output range linearly.
`timescale 1ns/1ps
module aic_bank
#(
   parameter int IN_CONV_CYCLES  = aic_pkg::IN_CONV_CYC,
   parameter int OUT_CONV_CYCLES = aic_pkg::OUT_CONV_CYC
)
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Controller state
   input  wire logic        scan_start,
   input  wire logic        plc_run,
   // Conversion circuitry
   input  wire logic [11:0] adc_sample,
   input  wire logic        adc_overscale,
   input  wire logic        link_data_err,
   input  wire logic        nvm_fault,
   input  wire logic        hw_fault,
   output logic             adc_start,
   output logic             adc_channel,
   output logic [1:0]       adc_current_mode,
   output logic [11:0]      dac_code,
   output logic             dac_current_mode,
   output logic             dac_enable,
   output logic             scan_busy,
   // Interrupt
   output logic             irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_IN_CONV, ST_IN_DIV, ST_OUT_CONV} aic_state_type;

   aic_div_if div_bus ();

   aic_state_type state_reg;
   aic_state_type state_next;
   logic [9:0]  ctrl_reg;
   logic [11:0] result_reg [2];
   logic [15:0] out_set_reg;
   logic [11:0] avg_reg [2];
   logic [7:0]  err_reg;
   logic [7:0]  mask_reg;
   logic [23:0] acc_reg [2];
   logic [11:0] nsamp_reg [2];
   logic        ch_reg;
   logic [12:0] timer_reg;
   logic [11:0] dac_reg;
   logic        dac_upd_reg;
   logic        start_reg;
   logic        div_start_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        irq_reg;
   logic        busy_reg;

   // APB decode: one wait state so read data comes from a flop
   logic        acc_phase;
   logic        wr_en;
   logic        rd_capture;
   logic        hit_ctrl;
   logic        hit_oset;
   logic        hit_avg1;
   logic        hit_avg2;
   logic        hit_err;
   logic        hit_mask;
   logic        mapped;
   logic [31:0] rd_mux;

   assign acc_phase  = psel && penable;
   assign rd_capture = acc_phase && !pready_reg;
   assign wr_en      = acc_phase && pready_reg && pwrite && !pslverr_reg;
   assign hit_ctrl   = paddr == aic_pkg::CTRL_OFS;
   assign hit_oset   = paddr == aic_pkg::OUT_SET_OFS;
   assign hit_avg1   = paddr == aic_pkg::IN1_AVG_OFS;
   assign hit_avg2   = paddr == aic_pkg::IN2_AVG_OFS;
   assign hit_err    = paddr == aic_pkg::ERR_OFS;
   assign hit_mask   = paddr == aic_pkg::IRQ_MASK_OFS;
   assign mapped     = hit_ctrl || hit_oset || hit_avg1 || hit_avg2 || hit_err || hit_mask
                       || paddr == aic_pkg::IN1_RES_OFS || paddr == aic_pkg::IN2_RES_OFS
                       || paddr == aic_pkg::MODEL_OFS;

   // Read selection; result and model words have no write path at all
   assign rd_mux =
      hit_ctrl ? {22'h000000, ctrl_reg} :
      (paddr == aic_pkg::IN1_RES_OFS) ? {20'h00000, result_reg[0]} :
      (paddr == aic_pkg::IN2_RES_OFS) ? {20'h00000, result_reg[1]} :
      hit_oset ? {16'h0000, out_set_reg} :
      hit_avg1 ? {20'h00000, avg_reg[0]} :
      hit_avg2 ? {20'h00000, avg_reg[1]} :
      hit_err  ? {24'h000000, err_reg} :
      hit_mask ? {24'h000000, mask_reg} :
      (paddr == aic_pkg::MODEL_OFS) ? {16'h0000, aic_pkg::MODEL_CODE} :
      32'h00000000;

   // Averaging count checks: out-of-range counts fall back to one sample
   logic        avg_bad_wr;
   logic        oset_bad_wr;
   logic [11:0] avg_eff;
   logic [11:0] nsamp_inc;
   logic [23:0] acc_sum;

   assign avg_bad_wr  = wr_en && (hit_avg1 || hit_avg2)
                        && (pwdata[15:0] == 16'h0000 || pwdata[15:0] > aic_pkg::AVG_MAX);
   assign oset_bad_wr = wr_en && hit_oset && pwdata[15:0] > aic_pkg::OUT_SET_MAX;
   assign avg_eff     = (avg_reg[ch_reg] == 12'h000) ? aic_pkg::AVG_RST : avg_reg[ch_reg];
   assign nsamp_inc   = nsamp_reg[ch_reg] + 12'h001;
   assign acc_sum     = acc_reg[ch_reg] + {12'h000, adc_sample};

   // Channel enables from the control word
   logic        in_dis;
   logic        in_dis_other;
   logic        timer_done;

   assign in_dis       = ch_reg ? ctrl_reg[aic_pkg::IN2_DIS_BIT] : ctrl_reg[aic_pkg::IN1_DIS_BIT];
   assign in_dis_other = ctrl_reg[aic_pkg::IN2_DIS_BIT];
   assign timer_done   = timer_reg == 13'h0000;

   // Error events; hardware sets win over software clears
   logic [7:0] err_set;
   logic       conv_end;

   assign conv_end = state_reg == ST_IN_CONV && timer_done;
   assign err_set[aic_pkg::ERR_OVS1_BIT] = conv_end && !ch_reg && adc_overscale;
   assign err_set[aic_pkg::ERR_OVS2_BIT] = conv_end && ch_reg && adc_overscale;
   assign err_set[aic_pkg::ERR_OSET_BIT] = oset_bad_wr;
   assign err_set[3]                     = 1'b0;
   assign err_set[aic_pkg::ERR_NVM_BIT]  = nvm_fault;
   assign err_set[aic_pkg::ERR_AVG_BIT]  = avg_bad_wr;
   assign err_set[aic_pkg::ERR_HW_BIT]   = hw_fault;
   assign err_set[aic_pkg::ERR_COMM_BIT] = conv_end && link_data_err;

   // Scan sequencer: inputs one then two, then the output, once per scan request
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:
            if (scan_start)
               state_next = ST_IN_CONV;
         ST_IN_CONV:
            if (in_dis && !ch_reg && in_dis_other)
               state_next = ST_OUT_CONV;
            else if (in_dis)
               state_next = ch_reg ? ST_OUT_CONV : ST_IN_CONV;
            else if (timer_done && nsamp_inc >= avg_eff)
               state_next = ST_IN_DIV;
            else if (timer_done)
               state_next = ch_reg ? ST_OUT_CONV : ST_IN_CONV;
         ST_IN_DIV:
            if (div_bus.done)
               state_next = ch_reg ? ST_OUT_CONV : ST_IN_CONV;
         ST_OUT_CONV:
            if (ctrl_reg[aic_pkg::OUT_DIS_BIT] || timer_done)
               state_next = ST_IDLE;
      endcase
   end

   // Sequencer state, channel pointer and conversion timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         busy_reg  <= 1'b0;
         ch_reg    <= 1'b0;
         timer_reg <= 13'h0000;
         start_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         busy_reg  <= state_next != ST_IDLE;
         start_reg <= 1'b0;
         if (state_next == ST_IN_CONV && (state_reg != ST_IN_CONV || timer_done || in_dis))
         begin
            // Each enabled input holds the converter for its full window
            ch_reg    <= (state_reg == ST_IDLE) ? 1'b0 : (state_reg == ST_IN_CONV) ? 1'b1
                         : ~ch_reg;
            timer_reg <= 13'(IN_CONV_CYCLES - 1);
            start_reg <= (state_reg == ST_IDLE) ? !ctrl_reg[aic_pkg::IN1_DIS_BIT]
                         : !ctrl_reg[aic_pkg::IN2_DIS_BIT];
         end
         else if (state_next == ST_OUT_CONV && state_reg != ST_OUT_CONV)
            timer_reg <= 13'(OUT_CONV_CYCLES - 1);
         else if (!timer_done)
            timer_reg <= timer_reg - 13'h0001;
      end
   end

   // Divider request for the finished averaging window
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_start_reg <= 1'b0;
      else
         div_start_reg <= state_reg == ST_IN_CONV && state_next == ST_IN_DIV;
   end

   assign div_bus.start    = div_start_reg;
   assign div_bus.dividend = acc_reg[ch_reg];
   assign div_bus.divisor  = avg_eff;

   aic_divider u_divider
   (
      .pclk    (pclk),
      .presetn (presetn),
      .div     (div_bus.slave)
   );

   // Per-channel accumulators and results; a skipped channel keeps everything
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_chan
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               acc_reg[gi]    <= 24'h000000;
               nsamp_reg[gi]  <= 12'h000;
               result_reg[gi] <= 12'h000;
            end
            else if (ch_reg == 1'(gi) && conv_end && !in_dis)
            begin
               acc_reg[gi]   <= acc_sum;
               nsamp_reg[gi] <= nsamp_inc;
            end
            else if (ch_reg == 1'(gi) && state_reg == ST_IN_DIV && div_bus.done)
            begin
               result_reg[gi] <= div_bus.quotient;
               acc_reg[gi]    <= 24'h000000;
               nsamp_reg[gi]  <= 12'h000;
            end
         end
      end
   endgenerate

   // Software registers; the reserved control positions never store
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg    <= aic_pkg::CTRL_RST;
         out_set_reg <= 16'h0000;
         avg_reg[0]  <= aic_pkg::AVG_RST;
         avg_reg[1]  <= aic_pkg::AVG_RST;
         mask_reg    <= 8'h00;
      end
      else if (wr_en)
      begin
         if (hit_ctrl)
            ctrl_reg <= pwdata[9:0] & aic_pkg::CTRL_WMASK;
         if (hit_oset)
            out_set_reg <= pwdata[15:0];
         if (hit_avg1)
            avg_reg[0] <= avg_bad_wr ? 12'h000 : pwdata[11:0];
         if (hit_avg2)
            avg_reg[1] <= avg_bad_wr ? 12'h000 : pwdata[11:0];
         if (hit_mask)
            mask_reg <= pwdata[7:0] & aic_pkg::ERR_WMASK;
      end
   end

   // Error word: write one to clear, a same-cycle event keeps its bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         err_reg <= 8'h00;
      else
         err_reg <= (err_reg & ~((wr_en && hit_err) ? pwdata[7:0] : 8'h00)) | err_set;
   end

   // Output channel: codes above full scale are rejected and the last good one kept
   logic [11:0] dac_next;
   logic        out_slot;

   assign out_slot = state_reg == ST_OUT_CONV && timer_done && !ctrl_reg[aic_pkg::OUT_DIS_BIT];
   always_comb
   begin
      dac_next = dac_reg;
      if (!plc_run && ctrl_reg[aic_pkg::HOLD_CAN_BIT])
         dac_next = aic_pkg::OUT_OFFSET;
      else if (plc_run && out_slot && out_set_reg <= aic_pkg::OUT_SET_MAX)
         dac_next = out_set_reg[11:0];
   end

   // Converter side flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dac_reg     <= aic_pkg::OUT_OFFSET;
         dac_upd_reg <= 1'b0;
      end
      else
      begin
         dac_reg     <= dac_next;
         dac_upd_reg <= !ctrl_reg[aic_pkg::OUT_DIS_BIT];
      end
   end

   // Bus answer and interrupt
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg  <= 32'h00000000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg     <= 1'b0;
      end
      else
      begin
         pready_reg  <= rd_capture;
         pslverr_reg <= rd_capture && !mapped;
         if (rd_capture)
            prdata_reg <= mapped ? rd_mux : 32'h00000000;
         irq_reg     <= |(err_reg & mask_reg);
      end
   end

   assign prdata           = prdata_reg;
   assign pready           = pready_reg;
   assign pslverr          = pslverr_reg;
   assign adc_start        = start_reg;
   assign adc_channel      = ch_reg;
   assign adc_current_mode = {ctrl_reg[aic_pkg::IN2_CUR_BIT], ctrl_reg[aic_pkg::IN1_CUR_BIT]};
   assign dac_current_mode = ctrl_reg[aic_pkg::OUT_CUR_BIT];
   assign dac_code         = dac_reg;
   assign dac_enable       = dac_upd_reg;
   assign scan_busy        = busy_reg;
   assign irq              = irq_reg;
endmodule

// ==== src/aic_pkg.sv ====
// Package: register map, field layout, reset values and timing of the analog I/O bank
package aic_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] IN1_RES_OFS   = 8'h04;
   localparam logic [7:0] IN2_RES_OFS   = 8'h08;
   localparam logic [7:0] OUT_SET_OFS   = 8'h0c;
   localparam logic [7:0] IN1_AVG_OFS   = 8'h10;
   localparam logic [7:0] IN2_AVG_OFS   = 8'h14;
   localparam logic [7:0] ERR_OFS       = 8'h18;
   localparam logic [7:0] MODEL_OFS     = 8'h1c;
   localparam logic [7:0] IRQ_MASK_OFS  = 8'h20;
   // Control word field positions
   localparam int IN1_CUR_BIT  = 0;
   localparam int IN2_CUR_BIT  = 1;
   localparam int OUT_CUR_BIT  = 2;
   localparam int HOLD_CAN_BIT = 6;
   localparam int IN1_DIS_BIT  = 7;
   localparam int IN2_DIS_BIT  = 8;
   localparam int OUT_DIS_BIT  = 9;
   localparam logic [9:0] CTRL_WMASK = 10'h3c7;
   // Error flag positions
   localparam int ERR_OVS1_BIT = 0;
   localparam int ERR_OVS2_BIT = 1;
   localparam int ERR_OSET_BIT = 2;
   localparam int ERR_NVM_BIT  = 4;
   localparam int ERR_AVG_BIT  = 5;
   localparam int ERR_HW_BIT   = 6;
   localparam int ERR_COMM_BIT = 7;
   localparam logic [7:0] ERR_WMASK = 8'hf7;
   // Reset values and limits
   localparam logic [9:0]  CTRL_RST     = 10'h000;
   localparam logic [11:0] AVG_RST      = 12'h001;
   localparam logic [15:0] AVG_MAX      = 16'h0fff;
   localparam logic [15:0] OUT_SET_MAX  = 16'h0fa0;
   localparam logic [11:0] OUT_OFFSET   = 12'h000;
   localparam logic [15:0] MODEL_CODE   = 16'h00a5;   // Arbitrary identity value
   // Conversion timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int IN_CONV_NS    = 90000;
   localparam int OUT_CONV_NS   = 50000;
   localparam int IN_CONV_CYC   = (IN_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OUT_CONV_CYC  = (OUT_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_W      = 12;
   localparam int ACC_W         = 24;
endpackage

// ==== src/aic_div_if.sv ====
// Interface: request and answer between the scan sequencer and the averaging divider
`timescale 1ns/1ps
interface aic_div_if;
   logic        start;
   logic [23:0] dividend;
   logic [11:0] divisor;
   logic        done;
   logic [11:0] quotient;
   modport master (output start, output dividend, output divisor,
                   input done, input quotient);
   modport slave  (input start, input dividend, input divisor,
                   output done, output quotient);
endinterface

// ==== src/aic_divider.sv ====
// Module: sequential restoring divider that turns an accumulated sum into an average
`timescale 1ns/1ps
module aic_divider
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Division request
   aic_div_if.slave  div
);
   logic [23:0] quo_reg;
   logic [12:0] rem_reg;
   logic [4:0]  step_reg;
   logic        busy_reg;
   logic        done_reg;
   logic [12:0] trial;
   logic        fits;

   // One quotient bit per cycle; a shared divider costs 24 cycles but no big array
   assign trial        = {rem_reg[11:0], quo_reg[23]};
   assign fits         = trial >= {1'b0, div.divisor};
   assign div.done     = done_reg;
   assign div.quotient = quo_reg[11:0];

   // Shift and subtract loop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         quo_reg  <= 24'h000000;
         rem_reg  <= 13'h0000;
         step_reg <= 5'h00;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         if (div.start && !busy_reg)
         begin
            quo_reg  <= div.dividend;
            rem_reg  <= 13'h0000;
            step_reg <= 5'h18;
            busy_reg <= 1'b1;
         end
         else if (busy_reg)
         begin
            rem_reg  <= fits ? (trial - {1'b0, div.divisor}) : trial;
            quo_reg  <= {quo_reg[22:0], fits};
            step_reg <= step_reg - 5'h01;
            if (step_reg == 5'h01)
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end
endmodule

// ==== verif/aic_conv_model.sv ====
// Partner model: conversion circuitry answering sample windows
`timescale 1ns/1ps
module aic_conv_model
#(
   parameter int WIN = 8
)
(
   // Bank side
   input  wire logic        pclk,
   input  wire logic        adc_start,
   input  wire logic        adc_channel,
   // Scenario control
   input  wire logic [11:0] code1,
   input  wire logic [11:0] code2,
   input  wire logic        ovs1,
   input  wire logic        bad_link,
   // Answers
   output logic      [11:0] adc_sample,
   output logic             adc_overscale,
   output logic             link_data_err
);
   int   cnt = 0;
   logic ch  = 1'b0;
   wire  [11:0] code = ch ? code2 : code1;
   // Window count; outside it the sample is inverted so stale data never looks right
   always @(posedge pclk)
   begin
      if (adc_start)
         cnt <= WIN + 2;
      else if (cnt > 0)
         cnt <= cnt - 1;
      if (adc_start)
         ch <= adc_channel;
   end
   // Outputs valid inside a window only
   assign adc_sample    = (cnt > 0) ? code : ~code;
   assign adc_overscale = (cnt > 0) && !ch && ovs1;
   assign link_data_err = (cnt > 0) && bad_link;
endmodule

// ==== verif/aic_bank_properties.sv ====
// Checker: concurrent properties on the ports of the analog I/O bank
`timescale 1ns/1ps
module aic_bank_chk
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Scan side
   input wire logic        scan_start,
   input wire logic        scan_busy,
   input wire logic        adc_start,
   input wire logic [1:0]  adc_current_mode,
   input wire logic        dac_current_mode,
   input wire logic        dac_enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed transfers; mode outputs settle one edge after the write, dac_enable two
   wire ctrl_wr = pready && pwrite && (paddr == aic_pkg::CTRL_OFS);
   wire rd_done = pready && !pwrite;
   chk_one_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_err_zero: assert property (pslverr |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_model_code: assert property (rd_done && paddr == aic_pkg::MODEL_OFS
      |-> prdata == {16'h0, aic_pkg::MODEL_CODE})
      else $error("model code wrong");
   chk_err_bit3: assert property (rd_done && paddr == aic_pkg::ERR_OFS
      |-> prdata[31:8] == 24'h0 && !prdata[3])
      else $error("error word spare bits set");
   chk_in_mode: assert property (ctrl_wr |=> ##1 adc_current_mode == $past(pwdata[1:0], 2))
      else $error("input mode not following control");
   chk_out_mode: assert property (ctrl_wr |=> ##1 dac_current_mode == $past(pwdata[2], 2))
      else $error("output mode not following control");
   chk_out_enable: assert property (ctrl_wr |=> ##1 dac_enable == !$past(pwdata[9], 2))
      else $error("output enable not following control");
   chk_scan_busy: assert property (scan_start && !scan_busy |=> scan_busy)
      else $error("scan not started");
   chk_start_pulse: assert property (adc_start |=> !adc_start)
      else $error("adc_start longer than one cycle");
endmodule
bind aic_bank aic_bank_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scan_start(scan_start), .scan_busy(scan_busy),
   .adc_start(adc_start), .adc_current_mode(adc_current_mode),
   .dac_current_mode(dac_current_mode), .dac_enable(dac_enable));

// ==== verif/tb_analog_io_control_bank.sv ====
// Testbench: register, scan, stop and fault scenarios of the analog I/O bank
`timescale 1ns/1ps
module tb_analog_io_control_bank;
   localparam logic [7:0] A_CTRL = aic_pkg::CTRL_OFS;
   localparam logic [7:0] A_IN1  = aic_pkg::IN1_RES_OFS;
   localparam logic [7:0] A_IN2  = aic_pkg::IN2_RES_OFS;
   localparam logic [7:0] A_OSET = aic_pkg::OUT_SET_OFS;
   localparam logic [7:0] A_AVG1 = aic_pkg::IN1_AVG_OFS;
   localparam logic [7:0] A_AVG2 = aic_pkg::IN2_AVG_OFS;
   localparam logic [7:0] A_ERR  = aic_pkg::ERR_OFS;
   localparam logic [7:0] A_MASK = aic_pkg::IRQ_MASK_OFS;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        scan_start = 1'b0;
   logic        plc_run = 1'b1;
   logic        nvm_fault = 1'b0;
   logic        hw_fault = 1'b0;
   logic [11:0] code1 = 12'h123;
   logic [11:0] code2 = 12'h100;
   logic        ovs1 = 1'b0;
   logic        bad_link = 1'b0;
   logic [31:0] prdata;
   logic [11:0] adc_sample, dac_code;
   logic [1:0]  adc_current_mode;
   logic        pready, pslverr, adc_overscale, link_data_err, adc_start, adc_channel;
   logic        dac_current_mode, dac_enable, scan_busy, irq;
   int          mismatches = 0;
   int          total_checks = 0;
   // Small windows keep the run short
   aic_bank #(.IN_CONV_CYCLES(8), .OUT_CONV_CYCLES(4)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scan_start(scan_start), .plc_run(plc_run), .adc_sample(adc_sample),
      .adc_overscale(adc_overscale), .link_data_err(link_data_err), .nvm_fault(nvm_fault),
      .hw_fault(hw_fault), .adc_start(adc_start), .adc_channel(adc_channel),
      .adc_current_mode(adc_current_mode), .dac_code(dac_code),
      .dac_current_mode(dac_current_mode), .dac_enable(dac_enable), .scan_busy(scan_busy),
      .irq(irq));
   aic_conv_model #(.WIN(8)) u_conv (.pclk(pclk), .adc_start(adc_start),
      .adc_channel(adc_channel), .code1(code1), .code2(code2), .ovs1(ovs1),
      .bad_link(bad_link), .adc_sample(adc_sample), .adc_overscale(adc_overscale),
      .link_data_err(link_data_err));
   always #10 pclk = ~pclk;
   // Compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   // One APB transfer; ends one edge after release so a following setup never collides
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      if (n >= 20)
         chk(32'h0, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask
   // One scan; a sequencer that never goes idle counts as a mismatch
   task automatic scan();
      int n;
      n = 0;
      scan_start <= 1'b1;
      @(posedge pclk);
      scan_start <= 1'b0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (scan_busy === 1'b1 && n < 500);
      if (n >= 500)
         chk(32'h0, 32'h1);
      repeat (40) @(posedge pclk);
   endtask
   task automatic pulse_wait();
      @(posedge pclk);
      hw_fault <= 1'b0;
      nvm_fault <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      rd(A_CTRL, 32'h0);
      rd(A_AVG1, 32'h1);
      rd(A_ERR, 32'h0);
      wr(A_CTRL, 32'hffff_ffff);
      rd(A_CTRL, 32'h3c7);
      rd(aic_pkg::MODEL_OFS, {16'h0, aic_pkg::MODEL_CODE});
      wr(A_IN1, 32'h0abc);
      rd(A_IN1, 32'h0);
      apb(1'b0, 8'h24, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      wr(A_CTRL, 32'h0);
   endtask
   task automatic t_avg();
      wr(A_AVG1, 32'h0);
      rd(A_ERR, 32'h20);
      wr(A_ERR, 32'h20);
      wr(A_AVG1, 32'hfff);
      rd(A_AVG1, 32'hfff);
      rd(A_ERR, 32'h0);
      wr(A_AVG1, 32'h1);
      wr(A_AVG2, 32'h2);
      wr(A_OSET, 32'd4000);
      wr(A_CTRL, 32'h7);
      scan();
      code2 <= 12'h203;
      scan();
      rd(A_IN1, 32'h123);
      rd(A_IN2, 32'h181);
      chk({20'h0, dac_code}, 32'hfa0);
      chk({29'h0, dac_current_mode, adc_current_mode}, 32'h7);
      wr(A_OSET, 32'd4001);
      rd(A_ERR, 32'h4);
      scan();
      chk({20'h0, dac_code}, 32'hfa0);
      wr(A_ERR, 32'hff);
   endtask
   task automatic t_unused();
      wr(A_CTRL, 32'h180);
      code1 <= 12'h777;
      code2 <= 12'h555;
      ovs1 <= 1'b1;
      scan();
      rd(A_IN1, 32'h123);
      rd(A_IN2, 32'h181);
      rd(A_ERR, 32'h0);
      wr(A_CTRL, 32'h0);
      scan();
      rd(A_ERR, 32'h1);
      ovs1 <= 1'b0;
      wr(A_ERR, 32'h1);
   endtask
   task automatic t_stop();
      wr(A_OSET, 32'h64);
      plc_run <= 1'b0;
      scan();
      chk({20'h0, dac_code}, 32'hfa0);
      wr(A_CTRL, 32'h40);
      repeat (4) @(posedge pclk);
      chk({20'h0, dac_code}, 32'h0);
      wr(A_CTRL, 32'h200);
      repeat (4) @(posedge pclk);
      chk({31'h0, dac_enable}, 32'h0);
      plc_run <= 1'b1;
      wr(A_CTRL, 32'h0);
   endtask
   task automatic t_fault();
      wr(A_ERR, 32'hff);
      wr(A_MASK, 32'h10);
      hw_fault <= 1'b1;
      pulse_wait();
      chk({31'h0, irq}, 32'h0);
      nvm_fault <= 1'b1;
      pulse_wait();
      chk({31'h0, irq}, 32'h1);
      bad_link <= 1'b1;
      scan();
      bad_link <= 1'b0;
      chk({20'h0, dac_code}, 32'h64);
      rd(A_ERR, 32'hd0);
      wr(A_ERR, 32'h10);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence after a 20-cycle reset
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_avg();
      t_unused();
      t_stop();
      t_fault();
      finish_test();
   end
   // Watchdog well beyond the thousand or so cycles the scenarios need
   initial
   begin
      #1ms;
      mismatches++;
      finish_test();
   end
endmodule
